// ==== rtl/lhcd_regs.vh ====
// Constants of the LCD host command decoder: command codes, bit positions, reset values.
// Included by every design file of the decoder; holds definitions only.
`ifndef LHCD_REGS_VH
`define LHCD_REGS_VH

`define LHCD_COL_LAST 8'hbf
`define LHCD_BANK_LAST 4'h8
`define LHCD_FLIP_BASE 8'h3f

`define LHCD_RST_COL 8'h00
`define LHCD_RST_BANK 4'h0
`define LHCD_RST_SCROLL 6'h00
`define LHCD_RST_SLOPE 2'h0
`define LHCD_RST_PUMP 3'h6
`define LHCD_RST_TRIM 8'h49
`define LHCD_RST_WALK 3'h1
`define LHCD_RST_PANEL 3'h0
`define LHCD_RST_GLASS 6'h08

`define LHCD_WALK_WRAP 0
`define LHCD_WALK_ORDER 1
`define LHCD_WALK_DIR 2
`define LHCD_PANEL_INV 0
`define LHCD_PANEL_ALLON 1
`define LHCD_PANEL_EN 2
`define LHCD_GLASS_CFLIP 1
`define LHCD_GLASS_RFLIP 2
`define LHCD_GLASS_RATE_LO 3
`define LHCD_GLASS_PART 5

`define LHCD_OP_COL_LO 8'h00
`define LHCD_OP_COL_HI 8'h10
`define LHCD_OP_SLOPE 8'h24
`define LHCD_OP_PUMP 8'h28
`define LHCD_OP_SCROLL 8'h40
`define LHCD_OP_BANK 8'hb0
`define LHCD_OP_TRIM 8'h81
`define LHCD_OP_PART 8'h84
`define LHCD_OP_WALK 8'h88
`define LHCD_OP_RATE 8'ha0
`define LHCD_OP_ALLON 8'ha4
`define LHCD_OP_INV 8'ha6
`define LHCD_OP_DISP 8'hae
`define LHCD_OP_MAP 8'hc0
`define LHCD_OP_SYSRST 8'he2
`define LHCD_OP_STATUS 8'hfe

`define LHCD_RAM_DEPTH 1728
`define LHCD_RAM_AW 11

`define LHCD_WAKE_CYCLES 4'h4
`endif

// ==== rtl/lhcd_fifo.v ====
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock, an active-low asynchronous reset and a freezing clock enable.
`timescale 1ns/100ps
`include "lhcd_regs.vh"
module lhcd_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire mclk_i,
	input wire arst_n_i,
	input wire ce_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	integer i;

	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rd_q];
	assign push = ce_i & in_valid_i & in_ready_o;
	assign pop = ce_i & out_valid_o & out_ready_i;

	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data_i;
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ==== rtl/lhcd_ram.v ====
// Display RAM, one byte per entry, written and read by index.
// Read data is registered; assumes the write and read port share one clock.
`timescale 1ns/100ps
`include "lhcd_regs.vh"
module lhcd_ram #(
	parameter DEPTH = 1728,
	parameter AW = 11
) (
	input wire mclk_i,
	input wire ce_i,
	input wire we_i,
	input wire [AW-1:0] addr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o
);
	reg [7:0] mem_q [0:DEPTH-1];

	// No reset: display contents are kept across reset, including the reset command.
	always @(posedge mclk_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem_q[addr_i] <= wdata_i;
			end
			rdata_o <= mem_q[addr_i];
		end
	end
endmodule

// ==== rtl/lhcd_decoder.v ====
// Host byte decoder of the LCD controller: commands, display RAM access, status.
// Assumes the host port logic hands over synchronous write strobes and read requests.
`timescale 1ns/100ps
`include "lhcd_regs.vh"
// How it works
// - A data write stores the byte in RAM at bank and column pointer.
// - A data read returns the RAM byte at bank and column pointer.
// - After every data byte the pointers step per walk control, reset 001b.
// - Without wrap the column pointer stops at the last column; bank-first, the bank pointer stops at its end.
// - With wrap the column clears and bank steps; bank-first, the bank wraps and column steps; banks wrap at RAM ends.
// - Order bit picks column-first or bank-first stepping.
// - Direction bit makes bank steps plus one or minus one.
// - Status byte one: strap, column flip, row flip, wrap, panel on, nvm bits.
// - Status byte two: revision, reset setting, six-bit trim offset.
// - Column pointer loads in two nibbles; host keeps it within 0 to 191.
// - Bank pointer loads 0 to 8; the last bank feeds the icon output.
// - Temperature slope selector loads two bits, reset 00b.
// - Pump configuration loads three bits, reset 110b.
// - Scroll offset loads six bits; icon output is not scrolled.
// - Trim command takes the next control byte as value, reset 49h.
// - Partial bit chooses the scanned row count formula, reset clear.
// - Frame rate selects one of four rates, reset 01b.
// - All-on forces columns on; inverse complements data; RAM unchanged.
// - Display enable leaves sleep, restores power, then enables drivers.
// - Row flip acts at once; column flip substitutes 63 minus column for columns 0 to 63.
// - Unknown control bytes do nothing.
// - Select low marks a control byte, high a data byte.
// - System reset restores control registers and keeps RAM.
module lhcd_decoder #(
	parameter RAM_DEPTH = 1728,
	parameter RAM_AW = 11,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2,
	parameter [3:0] WAKE_CYCLES = `LHCD_WAKE_CYCLES,
	parameter [0:0] SILICON_REV = 1'b0,
	parameter [0:0] NVM_PRESENT = 1'b0
) (
	input wire mclk_i,
	input wire arst_n_i,
	input wire ce_i,
	input wire wr_stb_i,
	input wire cd_sel_i,
	input wire [7:0] wr_data_i,
	output wire wr_ready_o,
	input wire rd_req_i,
	input wire rd_cd_sel_i,
	output reg rd_valid_o,
	output reg [7:0] rd_data_o,
	input wire vendor_strap_pin_i,
	input wire por_setting_pin_i,
	input wire [5:0] bias_trim_offset_i,
	input wire nvm_op_success_i,
	input wire nvm_action_state_i,
	input wire [5:0] last_row_electrode_i,
	input wire [5:0] first_active_row_i,
	input wire [5:0] last_active_row_i,
	output reg [7:0] column_pointer_o,
	output reg [3:0] bank_pointer_o,
	output reg [5:0] scroll_offset_o,
	output reg [1:0] temp_slope_select_o,
	output reg [2:0] pump_config_o,
	output reg [7:0] bias_trim_value_o,
	output reg [2:0] ram_walk_control_o,
	output reg [2:0] panel_output_control_o,
	output reg [5:0] glass_drive_control_o,
	output reg [6:0] scan_row_count_o,
	output reg sleep_exit_o,
	output reg power_on_o,
	output reg drivers_on_o,
	output reg icon_scroll_exempt_o
);
	localparam ST_SLEEP = 4'b0001;
	localparam ST_WAKE = 4'b0010;
	localparam ST_POWER = 4'b0100;
	localparam ST_ON = 4'b1000;

	reg strap_s1_q, strap_s2_q, por_s1_q, por_s2_q;
	reg ws_s1_q, ws_s2_q, ms_s1_q, ms_s2_q;
	reg [5:0] pmo_s1_q, pmo_s2_q;
	reg trim_pend_q;
	reg stat_idx_q;
	reg [3:0] st_q;
	reg [3:0] wait_q;
	reg rd_pend_q;
	reg rd_ram_q;
	reg [7:0] stat_q;

	wire fifo_valid;
	wire fifo_pop;
	wire [9:0] fifo_data;
	wire f_cd;
	wire f_rd;
	wire [7:0] f_byte;
	wire [7:0] ram_rdata;
	wire [7:0] col_eff;
	wire [RAM_AW-1:0] ram_addr;
	wire ram_we;
	wire data_xfer;
	wire ctl_wr;
	wire [7:0] status1;
	wire [7:0] status2;

	// Writes and reads share the FIFO so a read is ordered behind earlier writes.
	lhcd_fifo #(
		.WIDTH(10),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.in_valid_i(wr_stb_i | rd_req_i),
		.in_ready_o(wr_ready_o),
		.in_data_i(rd_req_i ? {1'b1, rd_cd_sel_i, 8'h00} : {1'b0, cd_sel_i, wr_data_i}),
		.out_valid_o(fifo_valid),
		.out_ready_i(!rd_pend_q),
		.out_data_o(fifo_data)
	);

	assign f_rd = fifo_data[9];
	assign f_cd = fifo_data[8];
	assign f_byte = fifo_data[7:0];
	// A read stalls the FIFO until its answer is out, so data reads see no later write.
	assign fifo_pop = ce_i & fifo_valid & !rd_pend_q;
	assign data_xfer = fifo_pop & f_cd;
	assign ctl_wr = fifo_pop & !f_cd & !f_rd;

	// The flip only reaches columns below 64; larger pointers use the plain value.
	assign col_eff = (glass_drive_control_o[`LHCD_GLASS_CFLIP] &&
		column_pointer_o <= `LHCD_FLIP_BASE) ?
		(`LHCD_FLIP_BASE - column_pointer_o) : column_pointer_o;
	assign ram_addr = bank_pointer_o * 8'd192 + {3'b000, col_eff};
	assign ram_we = data_xfer & !f_rd;

	lhcd_ram #(
		.DEPTH(RAM_DEPTH),
		.AW(RAM_AW)
	) u_ram (
		.mclk_i(mclk_i),
		.ce_i(ce_i),
		.we_i(ram_we),
		.addr_i(ram_addr),
		.wdata_i(f_byte),
		.rdata_o(ram_rdata)
	);

	assign status1 = {strap_s2_q, glass_drive_control_o[`LHCD_GLASS_CFLIP],
		glass_drive_control_o[`LHCD_GLASS_RFLIP], ram_walk_control_o[`LHCD_WALK_WRAP],
		panel_output_control_o[`LHCD_PANEL_EN], ws_s2_q, NVM_PRESENT, ms_s2_q};
	assign status2 = {SILICON_REV, por_s2_q, pmo_s2_q};

	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			por_s1_q <= 1'b0;
			por_s2_q <= 1'b0;
			ws_s1_q <= 1'b0;
			ws_s2_q <= 1'b0;
			ms_s1_q <= 1'b0;
			ms_s2_q <= 1'b0;
			pmo_s1_q <= 6'h00;
			pmo_s2_q <= 6'h00;
		end else if (ce_i) begin
			strap_s1_q <= vendor_strap_pin_i;
			strap_s2_q <= strap_s1_q;
			por_s1_q <= por_setting_pin_i;
			por_s2_q <= por_s1_q;
			ws_s1_q <= nvm_op_success_i;
			ws_s2_q <= ws_s1_q;
			ms_s1_q <= nvm_action_state_i;
			ms_s2_q <= ms_s1_q;
			pmo_s1_q <= bias_trim_offset_i;
			pmo_s2_q <= pmo_s1_q;
		end
	end

	// Command decode and pointer walk.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			column_pointer_o <= `LHCD_RST_COL;
			bank_pointer_o <= `LHCD_RST_BANK;
			scroll_offset_o <= `LHCD_RST_SCROLL;
			temp_slope_select_o <= `LHCD_RST_SLOPE;
			pump_config_o <= `LHCD_RST_PUMP;
			bias_trim_value_o <= `LHCD_RST_TRIM;
			ram_walk_control_o <= `LHCD_RST_WALK;
			panel_output_control_o <= `LHCD_RST_PANEL;
			glass_drive_control_o <= `LHCD_RST_GLASS;
			trim_pend_q <= 1'b0;
		end else if (ce_i) begin
			if (data_xfer) begin
				if (!ram_walk_control_o[`LHCD_WALK_ORDER]) begin
					if (column_pointer_o < `LHCD_COL_LAST) begin
						column_pointer_o <= column_pointer_o + 8'h01;
					end else if (ram_walk_control_o[`LHCD_WALK_WRAP]) begin
						column_pointer_o <= 8'h00;
						bank_pointer_o <= next_bank(bank_pointer_o,
							ram_walk_control_o[`LHCD_WALK_DIR]);
					end
				end else begin
					if (!at_bank_end(bank_pointer_o, ram_walk_control_o[`LHCD_WALK_DIR])) begin
						bank_pointer_o <= next_bank(bank_pointer_o,
							ram_walk_control_o[`LHCD_WALK_DIR]);
					end else if (ram_walk_control_o[`LHCD_WALK_WRAP]) begin
						bank_pointer_o <= next_bank(bank_pointer_o,
							ram_walk_control_o[`LHCD_WALK_DIR]);
						column_pointer_o <= (column_pointer_o < `LHCD_COL_LAST) ?
							column_pointer_o + 8'h01 : 8'h00;
					end
				end
			end else if (ctl_wr && trim_pend_q) begin
				bias_trim_value_o <= f_byte;
				trim_pend_q <= 1'b0;
			end else if (ctl_wr) begin
				if (f_byte[7:4] == `LHCD_OP_COL_LO >> 4) begin
					column_pointer_o[3:0] <= f_byte[3:0];
				end else if (f_byte[7:4] == `LHCD_OP_COL_HI >> 4) begin
					column_pointer_o[7:4] <= f_byte[3:0];
				end else if (f_byte[7:2] == `LHCD_OP_SLOPE >> 2) begin
					temp_slope_select_o <= f_byte[1:0];
				end else if (f_byte[7:3] == `LHCD_OP_PUMP >> 3) begin
					pump_config_o <= f_byte[2:0];
				end else if (f_byte[7:6] == `LHCD_OP_SCROLL >> 6) begin
					scroll_offset_o <= f_byte[5:0];
				end else if (f_byte[7:4] == `LHCD_OP_BANK >> 4) begin
					if (f_byte[3:0] <= `LHCD_BANK_LAST) begin
						bank_pointer_o <= f_byte[3:0];
					end
				end else if (f_byte == `LHCD_OP_TRIM) begin
					trim_pend_q <= 1'b1;
				end else if (f_byte[7:1] == `LHCD_OP_PART >> 1) begin
					glass_drive_control_o[`LHCD_GLASS_PART] <= f_byte[0];
				end else if (f_byte[7:3] == `LHCD_OP_WALK >> 3) begin
					ram_walk_control_o <= f_byte[2:0];
				end else if (f_byte[7:2] == `LHCD_OP_RATE >> 2) begin
					glass_drive_control_o[4:3] <= f_byte[1:0];
				end else if (f_byte[7:1] == `LHCD_OP_ALLON >> 1) begin
					panel_output_control_o[`LHCD_PANEL_ALLON] <= f_byte[0];
				end else if (f_byte[7:1] == `LHCD_OP_INV >> 1) begin
					panel_output_control_o[`LHCD_PANEL_INV] <= f_byte[0];
				end else if (f_byte[7:1] == `LHCD_OP_DISP >> 1) begin
					panel_output_control_o[`LHCD_PANEL_EN] <= f_byte[0];
				end else if (f_byte[7:3] == `LHCD_OP_MAP >> 3 && !f_byte[0]) begin
					glass_drive_control_o[2:1] <= f_byte[2:1];
				end else if (f_byte == `LHCD_OP_SYSRST) begin
					column_pointer_o <= `LHCD_RST_COL;
					bank_pointer_o <= `LHCD_RST_BANK;
					scroll_offset_o <= `LHCD_RST_SCROLL;
					temp_slope_select_o <= `LHCD_RST_SLOPE;
					pump_config_o <= `LHCD_RST_PUMP;
					bias_trim_value_o <= `LHCD_RST_TRIM;
					ram_walk_control_o <= `LHCD_RST_WALK;
					panel_output_control_o <= `LHCD_RST_PANEL;
					glass_drive_control_o <= `LHCD_RST_GLASS;
				end
				// Any other pattern falls through unchanged.
			end
		end
	end

	// Status pair index: a request byte restarts at the first byte.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_idx_q <= 1'b0;
		end else if (ce_i) begin
			if (ctl_wr && !trim_pend_q && f_byte == `LHCD_OP_STATUS) begin
				stat_idx_q <= 1'b0;
			end else if (fifo_pop && f_rd && !f_cd) begin
				stat_idx_q <= !stat_idx_q;
			end
		end
	end

	// Reads answer one cycle after the pop edge: address in and RAM data out at the pop, then latch.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_pend_q <= 1'b0;
			rd_ram_q <= 1'b0;
			stat_q <= 8'h00;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
		end else if (ce_i) begin
			rd_valid_o <= 1'b0;
			if (fifo_pop && f_rd) begin
				rd_pend_q <= 1'b1;
				rd_ram_q <= f_cd;
				stat_q <= stat_idx_q ? status2 : status1;
			end else if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				rd_valid_o <= 1'b1;
				rd_data_o <= rd_ram_q ? ram_rdata : stat_q;
			end
		end
	end

	// Panel power sequence: wake, then power, then drivers.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= ST_SLEEP;
			wait_q <= 4'h0;
			sleep_exit_o <= 1'b0;
			power_on_o <= 1'b0;
			drivers_on_o <= 1'b0;
		end else if (ce_i) begin
			case (st_q)
				ST_SLEEP: begin
					if (panel_output_control_o[`LHCD_PANEL_EN]) begin
						st_q <= ST_WAKE;
						sleep_exit_o <= 1'b1;
						wait_q <= WAKE_CYCLES;
					end
				end
				ST_WAKE: begin
					if (wait_q == 4'h0) begin
						st_q <= ST_POWER;
						power_on_o <= 1'b1;
						wait_q <= WAKE_CYCLES;
					end else begin
						wait_q <= wait_q - 4'h1;
					end
				end
				ST_POWER: begin
					if (wait_q == 4'h0) begin
						st_q <= ST_ON;
						drivers_on_o <= 1'b1;
					end else begin
						wait_q <= wait_q - 4'h1;
					end
				end
				ST_ON: begin
					if (!panel_output_control_o[`LHCD_PANEL_EN]) begin
						st_q <= ST_SLEEP;
						sleep_exit_o <= 1'b0;
						power_on_o <= 1'b0;
						drivers_on_o <= 1'b0;
					end
				end
				default: begin
					st_q <= ST_SLEEP;
				end
			endcase
			if (st_q != ST_ON && st_q != ST_SLEEP &&
				!panel_output_control_o[`LHCD_PANEL_EN]) begin
				st_q <= ST_SLEEP;
				sleep_exit_o <= 1'b0;
				power_on_o <= 1'b0;
				drivers_on_o <= 1'b0;
			end
		end
	end

	// Scanned row count and icon marker.
	always @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scan_row_count_o <= 7'h40;
			icon_scroll_exempt_o <= 1'b0;
		end else if (ce_i) begin
			if (glass_drive_control_o[`LHCD_GLASS_PART]) begin
				scan_row_count_o <= {1'b0, last_active_row_i} -
					{1'b0, first_active_row_i} + 7'h01;
			end else begin
				scan_row_count_o <= {1'b0, last_row_electrode_i} + 7'h01;
			end
			icon_scroll_exempt_o <= (bank_pointer_o == `LHCD_BANK_LAST);
		end
	end

	function [3:0] next_bank;
		input [3:0] b;
		input dir;
		begin
			if (!dir) begin
				next_bank = (b >= `LHCD_BANK_LAST) ? 4'h0 : b + 4'h1;
			end else begin
				next_bank = (b == 4'h0) ? `LHCD_BANK_LAST : b - 4'h1;
			end
		end
	endfunction

	function at_bank_end;
		input [3:0] b;
		input dir;
		begin
			at_bank_end = dir ? (b == 4'h0) : (b >= `LHCD_BANK_LAST);
		end
	endfunction
endmodule

// ==== tb/lhcd_assertions.sv ====
// Port-level checks of the LCD host byte decoder.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/100ps
module lhcd_chk (
	input wire mclk_i,
	input wire arst_n_i,
	input wire ce_i,
	input wire rd_req_i,
	input wire wr_ready_o,
	input wire rd_valid_o,
	input wire [7:0] column_pointer_o,
	input wire [3:0] bank_pointer_o,
	input wire [2:0] panel_output_control_o,
	input wire [5:0] glass_drive_control_o,
	input wire [5:0] last_row_electrode_i,
	input wire [5:0] first_active_row_i,
	input wire [5:0] last_active_row_i,
	input wire [6:0] scan_row_count_o,
	input wire sleep_exit_o,
	input wire power_on_o,
	input wire drivers_on_o,
	input wire icon_scroll_exempt_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	property p_bank_range;
		bank_pointer_o <= 4'h8;
	endproperty
	a_bank_range: assert property (p_bank_range) else $error("bank pointer too big");
	property p_col_range;
		column_pointer_o <= 8'hbf;
	endproperty
	a_col_range: assert property (p_col_range) else $error("column pointer too big");
	property p_icon;
		$stable(bank_pointer_o) |-> icon_scroll_exempt_o == (bank_pointer_o == 4'h8);
	endproperty
	a_icon: assert property (p_icon) else $error("icon flag wrong");
	// The count is registered from the partial bit, so both sides look one cycle back.
	property p_scan;
		$past(arst_n_i) && $past(ce_i) |-> scan_row_count_o == ($past(glass_drive_control_o[5]) ?
			{1'b0, $past(last_active_row_i)} - {1'b0, $past(first_active_row_i)} + 7'h1 :
			{1'b0, $past(last_row_electrode_i)} + 7'h1);
	endproperty
	a_scan: assert property (p_scan) else $error("scan row count wrong");
	property p_seq;
		drivers_on_o |-> power_on_o && sleep_exit_o;
	endproperty
	a_seq: assert property (p_seq) else $error("drivers on before power");
	property p_power_wake;
		$rose(power_on_o) |-> $past(sleep_exit_o);
	endproperty
	a_power_wake: assert property (p_power_wake) else $error("power before wake");
	property p_wake_bound;
		$rose(panel_output_control_o[2]) |-> ##[1:40] drivers_on_o;
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("drivers late");
	property p_rd_pulse;
		rd_valid_o |=> !rd_valid_o;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read answer too long");
	property p_read_answer;
		ce_i && rd_req_i && wr_ready_o |-> ##[3:30] rd_valid_o;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	c_drivers: cover property (drivers_on_o);
	c_full: cover property (!wr_ready_o);
	c_partial: cover property (glass_drive_control_o[5]);
endmodule

bind lhcd_decoder lhcd_chk chk_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
	.rd_req_i(rd_req_i), .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o),
	.column_pointer_o(column_pointer_o), .bank_pointer_o(bank_pointer_o),
	.panel_output_control_o(panel_output_control_o),
	.glass_drive_control_o(glass_drive_control_o), .last_row_electrode_i(last_row_electrode_i),
	.first_active_row_i(first_active_row_i), .last_active_row_i(last_active_row_i),
	.scan_row_count_o(scan_row_count_o), .sleep_exit_o(sleep_exit_o), .power_on_o(power_on_o),
	.drivers_on_o(drivers_on_o), .icon_scroll_exempt_o(icon_scroll_exempt_o));

// ==== tb/lhcd_host.sv ====
// Host processor model on the decoder's byte port.
// Assumes requests are taken at a rising edge of mclk_i while wr_ready_i is high.
`timescale 1ns/100ps
module lhcd_host (
	input wire mclk_i,
	input wire wr_ready_i,
	input wire rd_valid_i,
	input wire [7:0] rd_data_i,
	output logic wr_stb_o,
	output logic cd_sel_o,
	output logic [7:0] wr_data_o,
	output logic rd_req_o,
	output logic rd_cd_sel_o
);
	initial begin
		wr_stb_o = 1'b0;
		cd_sel_o = 1'b0;
		wr_data_o = 8'h00;
		rd_req_o = 1'b0;
		rd_cd_sel_o = 1'b0;
	end
	// Ready is read just after an edge, where it has settled, then held through the taking edge.
	task hold;
		begin
			while (!wr_ready_i) begin
				@(posedge mclk_i);
				#1;
			end
			@(posedge mclk_i);
			#1;
		end
	endtask
	task put(input logic cd, input logic [7:0] b);
		begin
			@(posedge mclk_i);
			#1;
			wr_stb_o = 1'b1;
			cd_sel_o = cd;
			wr_data_o = b;
			hold;
			wr_stb_o = 1'b0;
			// A released line shows the inverse, so a stale byte never passes for a held one.
			wr_data_o = ~b;
		end
	endtask
	task get(input logic cd, output logic [7:0] b);
		begin
			@(posedge mclk_i);
			#1;
			rd_req_o = 1'b1;
			rd_cd_sel_o = cd;
			hold;
			rd_req_o = 1'b0;
			rd_cd_sel_o = ~cd;
			for (int i = 0; i < 40 && !rd_valid_i; i++) begin
				@(posedge mclk_i);
				#1;
			end
			b = rd_valid_i ? rd_data_i : 8'hxx;
		end
	endtask
	task status(output logic [7:0] s1, output logic [7:0] s2);
		begin
			put(1'b0, 8'hfe);
			get(1'b0, s1);
			get(1'b0, s2);
		end
	endtask
	task burst(input int n);
		int t;
		logic r;
		begin
			t = 0;
			@(posedge mclk_i);
			#1;
			rd_req_o = 1'b1;
			rd_cd_sel_o = 1'b0;
			while (t < n) begin
				r = wr_ready_i;
				@(posedge mclk_i);
				#1;
				if (r) t = t + 1;
			end
			rd_req_o = 1'b0;
			rd_cd_sel_o = 1'b1;
		end
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the LCD host byte decoder.
// Assumes the host model drives the byte port; the bench drives the pins.
`timescale 1ns/100ps
module testbench;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic strap = 1'b1;
	logic por = 1'b0;
	logic nvm_ok = 1'b1;
	logic nvm_act = 1'b0;
	logic [5:0] offs = 6'h2d;
	logic wr_stb_i, cd_sel_i, rd_req_i, rd_cd_sel_i, wr_ready_o, rd_valid_o;
	logic sleep_exit_o, power_on_o, drivers_on_o, icon_scroll_exempt_o;
	logic [7:0] wr_data_i, rd_data_o, column_pointer_o, bias_trim_value_o;
	logic [3:0] bank_pointer_o;
	logic [5:0] scroll_offset_o, glass_drive_control_o;
	logic [1:0] temp_slope_select_o;
	logic [2:0] pump_config_o, ram_walk_control_o, panel_output_control_o;
	logic [6:0] scan_row_count_o;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int nval = 0;
	int nfull = 0;
	always #2.5 mclk_i = ~mclk_i;
	lhcd_decoder dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
		.wr_stb_i(wr_stb_i), .cd_sel_i(cd_sel_i), .wr_data_i(wr_data_i),
		.wr_ready_o(wr_ready_o), .rd_req_i(rd_req_i), .rd_cd_sel_i(rd_cd_sel_i),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .vendor_strap_pin_i(strap),
		.por_setting_pin_i(por), .bias_trim_offset_i(offs), .nvm_op_success_i(nvm_ok),
		.nvm_action_state_i(nvm_act), .last_row_electrode_i(6'h3f),
		.first_active_row_i(6'h05), .last_active_row_i(6'h2c),
		.column_pointer_o(column_pointer_o), .bank_pointer_o(bank_pointer_o),
		.scroll_offset_o(scroll_offset_o), .temp_slope_select_o(temp_slope_select_o),
		.pump_config_o(pump_config_o), .bias_trim_value_o(bias_trim_value_o),
		.ram_walk_control_o(ram_walk_control_o), .panel_output_control_o(panel_output_control_o),
		.glass_drive_control_o(glass_drive_control_o), .scan_row_count_o(scan_row_count_o),
		.sleep_exit_o(sleep_exit_o), .power_on_o(power_on_o), .drivers_on_o(drivers_on_o),
		.icon_scroll_exempt_o(icon_scroll_exempt_o));
	lhcd_host host_u (.mclk_i(mclk_i), .wr_ready_i(wr_ready_o), .rd_valid_i(rd_valid_o),
		.rd_data_i(rd_data_o), .wr_stb_o(wr_stb_i), .cd_sel_o(cd_sel_i),
		.wr_data_o(wr_data_i), .rd_req_o(rd_req_i), .rd_cd_sel_o(rd_cd_sel_i));
	function logic [7:0] obs(input logic [3:0] k);
		case (k)
			4'h0: obs = column_pointer_o;
			4'h1: obs = {4'h0, bank_pointer_o};
			4'h2: obs = {2'h0, scroll_offset_o};
			4'h3: obs = {6'h00, temp_slope_select_o};
			4'h4: obs = {5'h00, pump_config_o};
			4'h5: obs = bias_trim_value_o;
			4'h6: obs = {5'h00, ram_walk_control_o};
			4'h7: obs = {5'h00, panel_output_control_o};
			4'h8: obs = {2'h0, glass_drive_control_o};
			default: obs = {5'h00, sleep_exit_o, power_on_o, drivers_on_o};
		endcase
	endfunction
	task close_out;
		begin
			if (bad_count == 0 && checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// A control byte takes effect on the next edge after it is taken, so four edges leave margin.
	task cmd(input logic [7:0] b);
		begin
			host_u.put(1'b0, b);
			repeat (4) @(posedge mclk_i);
			#1;
		end
	endtask
	task ptr(input logic [3:0] bank, input logic [7:0] col);
		begin
			cmd({4'hb, bank});
			cmd({4'h0, col[3:0]});
			cmd({4'h1, col[7:4]});
		end
	endtask
	task wait_for(input logic [3:0] k, input logic [7:0] exp);
		begin
			for (int i = 0; i < 80 && obs(k) !== exp; i++) begin
				@(posedge mclk_i);
				#1;
			end
			chk(obs(k), exp);
		end
	endtask
	task t_defaults;
		logic [7:0] dflt [0:8];
		begin
			dflt = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h49, 8'h01, 8'h00, 8'h08};
			for (int k = 0; k < 9; k++) chk(obs(4'(k)), dflt[k]);
		end
	endtask
	task t_table;
		logic [23:0] tbl [0:27];
		begin
			tbl = '{24'h240300, 24'h250301, 24'h260302, 24'h270303, 24'h2b0403, 24'h2c0404,
				24'h7f023f, 24'hb30103, 24'hb80108, 24'hb90108, 24'h0a000a, 24'h1b00ba,
				24'h850828, 24'ha30838, 24'ha00820, 24'hc60826, 24'ha20836, 24'ha1082e,
				24'h84080e, 24'ha50702, 24'ha70703, 24'ha40701, 24'ha60700, 24'h8e0606,
				24'h810549, 24'h2a052a, 24'he30404, 24'he80606};
			for (int i = 0; i < 28; i++) begin
				cmd(tbl[i][23:16]);
				chk(obs(tbl[i][11:8]), tbl[i][7:0]);
			end
		end
	endtask
	task t_status;
		logic [7:0] s1, s2;
		begin
			host_u.status(s1, s2);
			chk(s1, 8'h94);
			chk(s2, 8'h2d);
			por = 1'b1;
			nvm_act = 1'b1;
			cmd(8'hc4);
			cmd(8'haf);
			wait_for(4'h9, 8'h07);
			host_u.status(s1, s2);
			chk(s1, 8'hbd);
			chk(s2, 8'h6d);
		end
	endtask
	task t_walk;
		logic [7:0] d;
		begin
			cmd(8'h89);
			ptr(4'h2, 8'hbe);
			for (int i = 1; i < 4; i++) host_u.put(1'b1, 8'(8'h11 * i));
			cmd(8'he3);
			chk(obs(4'h0), 8'h01);
			chk(obs(4'h1), 8'h03);
			ptr(4'h2, 8'hbe);
			for (int i = 1; i < 4; i++) begin
				host_u.get(1'b1, d);
				chk(d, 8'(8'h11 * i));
			end
			chk(obs(4'h1), 8'h03);
			cmd(8'h8d);
			ptr(4'h0, 8'hbf);
			host_u.put(1'b1, 8'h44);
			cmd(8'he3);
			chk(obs(4'h1), 8'h08);
			chk(obs(4'h0), 8'h00);
			cmd(8'h88);
			ptr(4'h4, 8'hbf);
			host_u.put(1'b1, 8'h55);
			host_u.put(1'b1, 8'h66);
			cmd(8'he3);
			chk(obs(4'h0), 8'hbf);
			chk(obs(4'h1), 8'h04);
			ptr(4'h4, 8'hbf);
			host_u.get(1'b1, d);
			chk(d, 8'h66);
			cmd(8'h8b);
			ptr(4'h7, 8'h05);
			host_u.put(1'b1, 8'h77);
			cmd(8'he3);
			chk(obs(4'h1), 8'h08);
			chk(obs(4'h0), 8'h05);
			host_u.put(1'b1, 8'h78);
			cmd(8'he3);
			chk(obs(4'h1), 8'h00);
			chk(obs(4'h0), 8'h06);
			cmd(8'h89);
			cmd(8'hc2);
			ptr(4'h1, 8'h0a);
			host_u.put(1'b1, 8'h5a);
			cmd(8'hc0);
			ptr(4'h1, 8'h35);
			host_u.get(1'b1, d);
			chk(d, 8'h5a);
		end
	endtask
	task t_pixels;
		logic [7:0] d;
		begin
			cmd(8'ha7);
			cmd(8'ha5);
			ptr(4'h2, 8'hbe);
			host_u.get(1'b1, d);
			chk(d, 8'h11);
			cmd(8'hae);
			wait_for(4'h9, 8'h00);
		end
	endtask
	task t_fill;
		int n0, f0;
		begin
			n0 = nval;
			f0 = nfull;
			host_u.burst(8);
			for (int i = 0; i < 60 && nval != n0 + 8; i++) @(posedge mclk_i);
			#1;
			chk(8'(nval - n0), 8'h08);
			chk({7'h00, nfull != f0}, 8'h01);
		end
	endtask
	task t_reset2;
		begin
			cmd(8'h2a);
			arst_n_i = 1'b0;
			repeat (2) @(posedge mclk_i);
			#1 arst_n_i = 1'b1;
			t_defaults;
		end
	endtask
	// A byte offered while the enable is low must be lost, not queued.
	task t_freeze;
		begin
			ce_i = 1'b0;
			cmd(8'h27);
			chk(obs(4'h3), 8'h00);
			ce_i = 1'b1;
			cmd(8'h26);
			chk(obs(4'h3), 8'h02);
		end
	endtask
	task t_rows;
		begin
			cmd(8'h85);
			chk({1'b0, scan_row_count_o}, 8'h28);
			cmd(8'h84);
			chk({1'b0, scan_row_count_o}, 8'h40);
		end
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (rd_valid_o) nval <= nval + 1;
		if (!wr_ready_o) nfull <= nfull + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			close_out;
		end
	end
	initial begin
		repeat (8) @(posedge mclk_i);
		#1 arst_n_i = 1'b1;
		t_defaults;
		t_table;
		cmd(8'he2);
		t_defaults;
		t_status;
		t_walk;
		t_pixels;
		t_fill;
		t_reset2;
		t_freeze;
		t_rows;
		close_out;
	end
endmodule
